/* File: rie_rtc_irq_ctrl.sv */
`timescale 1ns/1ps
`include "rie_cfg.svh"
module rie_rtc_irq_ctrl
  import rie_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [`RIE_SRC_W-1:0] rtc_event,
  output logic rtc_irq
);
  // bus front end outputs
  logic wr_en; // write data phase ends this cycle
  logic rd_load; // read wait cycle, hrdata loads at its end
  logic [`RIE_ADDR_W-1:0] acc_addr; // latched address phase

  // register state
  rie_src_type mask_q; // one = source unmasked
  rie_src_type raw_q; // sticky event status
  logic [31:0] hrdata_q; // read data holding register
  logic irq_q; // registered interrupt line
  logic hresp_q; // response is always OKAY

  // only the low address bits decode; the window aliases above
  rie_ahb_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr[`RIE_ADDR_W-1:0]),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .wr_en(wr_en),
    .rd_load(rd_load),
    .acc_addr(acc_addr)
  );

  // write decode
  wire wr_set = wr_en && (acc_addr == `RIE_OFS_SET);
  wire wr_clr = wr_en && (acc_addr == `RIE_OFS_CLR);
  wire wr_raw = wr_en && (acc_addr == `RIE_OFS_RAW);

  // unmask requests: only bits written as one count
  rie_src_type set_vec;
  assign set_vec[`RIE_BIT_TICK] = wr_set && hwdata[`RIE_BIT_TICK]; // RL1
  assign set_vec[`RIE_BIT_CEN] = wr_set && hwdata[`RIE_BIT_CEN]; // RL2
  // year, month, date, week, hour, minute, second rollover
  assign set_vec[`RIE_ROLL_HI:`RIE_ROLL_LO] =
    {7{wr_set}} & hwdata[`RIE_ROLL_HI:`RIE_ROLL_LO]; // RL3
  assign set_vec[`RIE_BIT_ALL] = wr_set && hwdata[`RIE_BIT_ALL]; // RL4
  // century, year, month, date, week, hour, minute, second match
  assign set_vec[`RIE_MATCH_HI:`RIE_MATCH_LO] =
    {8{wr_set}} & hwdata[`RIE_MATCH_HI:`RIE_MATCH_LO]; // RL5

  // mask requests mirror the unmask layout
  rie_src_type clr_vec;
  assign clr_vec[`RIE_BIT_TICK] = wr_clr && hwdata[`RIE_BIT_TICK]; // RL6
  assign clr_vec[`RIE_BIT_CEN] = wr_clr && hwdata[`RIE_BIT_CEN]; // RL7
  assign clr_vec[`RIE_ROLL_HI:`RIE_ROLL_LO] =
    {7{wr_clr}} & hwdata[`RIE_ROLL_HI:`RIE_ROLL_LO]; // RL8
  assign clr_vec[`RIE_BIT_ALL] = wr_clr && hwdata[`RIE_BIT_ALL]; // RL9
  assign clr_vec[`RIE_MATCH_HI:`RIE_MATCH_LO] =
    {8{wr_clr}} & hwdata[`RIE_MATCH_HI:`RIE_MATCH_LO]; // RL10

  // mask state: zeros leave bits alone, clear beats set
  // the bus cannot strobe both in one cycle, so this is a safety net
  rie_flag_reg #(
    .W(`RIE_SRC_W),
    .SET_WINS(1'b0)
  ) u_mask (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(set_vec),
    .clr(clr_vec),
    .q(mask_q)
  ); // RL14

  // raw status clears by writing ones; a live event wins the race
  wire [`RIE_SRC_W-1:0] raw_clr =
    {`RIE_SRC_W{wr_raw}} & hwdata[`RIE_SRC_W-1:0];

  // sticky raw status, masking never hides it
  rie_flag_reg #(
    .W(`RIE_SRC_W),
    .SET_WINS(1'b1)
  ) u_raw (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(rtc_event),
    .clr(raw_clr),
    .q(raw_q)
  ); // RL13

  // read decode; set and clear registers read as zero
  wire rd_mask = (acc_addr == `RIE_OFS_MASK);
  wire rd_raw = (acc_addr == `RIE_OFS_RAW);
  wire [`RIE_SRC_W-1:0] rd_field =
    rd_mask ? mask_q : (rd_raw ? raw_q : '0); // RL12
  // reserved upper bits forced to zero
  wire [31:0] rd_word = {{`RIE_RSV_W{1'b0}}, rd_field}; // RL11

  // unmasked pending sources
  wire irq_d = |(raw_q & mask_q); // RL15

  // read data holds between reads so the bus sees a stable value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `RIE_RDATA_RST;
    end else if (rd_load) begin
      hrdata_q <= rd_word;
    end
  end

  // interrupt line and response, both registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
      hresp_q <= `RIE_HRESP_OKAY;
    end else begin
      irq_q <= irq_d; // RL15
      hresp_q <= `RIE_HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign rtc_irq = irq_q;

  // checks, built from the bus view of each transfer

  // address phase taken by this slave
  wire chk_acc = hsel && hready && htrans[1];
  wire chk_rd = chk_acc && !hwrite;
  wire chk_wr = chk_acc && hwrite && (hsize == `RIE_HSIZE_WORD);
  wire [`RIE_ADDR_W-1:0] chk_a = haddr[`RIE_ADDR_W-1:0];
  // writes that must leave the mask alone: narrow or off set/clear
  wire chk_dead_wr = chk_acc && hwrite &&
    ((hsize != `RIE_HSIZE_WORD) ||
     ((chk_a != `RIE_OFS_SET) && (chk_a != `RIE_OFS_CLR)));
  // reads of the write-only places
  wire chk_rd_wo = chk_rd &&
    ((chk_a == `RIE_OFS_SET) || (chk_a == `RIE_OFS_CLR));

  // a word write to the unmask register, then its data phase
  sequence s_set_wr;
    chk_wr && (chk_a == `RIE_OFS_SET) ##1 1'b1;
  endsequence

  // a word write to the mask register, then its data phase
  sequence s_clr_wr;
    chk_wr && (chk_a == `RIE_OFS_CLR) ##1 1'b1;
  endsequence

  // a read of the mask state word
  sequence s_rd_mask;
    chk_rd && (chk_a == `RIE_OFS_MASK);
  endsequence

  // a read of the raw status word
  sequence s_rd_raw;
    chk_rd && (chk_a == `RIE_OFS_RAW);
  endsequence

  // a word write to the raw status word, then its data phase
  sequence s_raw_wr;
    chk_wr && (chk_a == `RIE_OFS_RAW) ##1 1'b1;
  endsequence

  // a write with no effect on the mask, then its data phase
  sequence s_dead_wr;
    chk_dead_wr ##1 1'b1;
  endsequence

  // set writes: each one bit raises its mask bit
  AST_SET_TICK: assert property ( // RL1
    @(posedge hclk) disable iff (!hresetn)
    s_set_wr ##0 hwdata[17] |=> mask_q[17])
    else $error("tick not unmasked by set write");

  AST_SET_CEN: assert property ( // RL2
    @(posedge hclk) disable iff (!hresetn)
    s_set_wr ##0 hwdata[16] |=> mask_q[16])
    else $error("century rollover not unmasked");

  AST_SET_ROLL: assert property ( // RL3
    @(posedge hclk) disable iff (!hresetn)
    s_set_wr |=>
      ((mask_q[15:9] & $past(hwdata[15:9])) ==
       $past(hwdata[15:9])))
    else $error("rollover bits not unmasked");

  AST_SET_ALL: assert property ( // RL4
    @(posedge hclk) disable iff (!hresetn)
    s_set_wr ##0 hwdata[8] |=> mask_q[8])
    else $error("full match not unmasked");

  AST_SET_MATCH: assert property ( // RL5
    @(posedge hclk) disable iff (!hresetn)
    s_set_wr |=>
      ((mask_q[7:0] & $past(hwdata[7:0])) ==
       $past(hwdata[7:0])))
    else $error("field match bits not unmasked");

  // clear writes: each one bit drops its mask bit
  AST_CLR_TICK: assert property ( // RL6
    @(posedge hclk) disable iff (!hresetn)
    s_clr_wr ##0 hwdata[17] |=> !mask_q[17])
    else $error("tick not masked by clear write");

  AST_CLR_CEN: assert property ( // RL7
    @(posedge hclk) disable iff (!hresetn)
    s_clr_wr ##0 hwdata[16] |=> !mask_q[16])
    else $error("century rollover not masked");

  AST_CLR_ROLL: assert property ( // RL8
    @(posedge hclk) disable iff (!hresetn)
    s_clr_wr |=> ((mask_q[15:9] & $past(hwdata[15:9])) == 7'h00))
    else $error("rollover bits not masked");

  AST_CLR_ALL: assert property ( // RL9
    @(posedge hclk) disable iff (!hresetn)
    s_clr_wr ##0 hwdata[8] |=> !mask_q[8])
    else $error("full match not masked");

  AST_CLR_MATCH: assert property ( // RL10
    @(posedge hclk) disable iff (!hresetn)
    s_clr_wr |=> ((mask_q[7:0] & $past(hwdata[7:0])) == 8'h00))
    else $error("field match bits not masked");

  // reads: one wait state, then the word with reserved bits low
  AST_RSV_ZERO: assert property ( // RL11
    @(posedge hclk) disable iff (!hresetn)
    chk_rd |-> ##2 hreadyout && (hrdata[31:18] == 14'h0000))
    else $error("reserved read bits not zero");

  AST_RD_MASK: assert property ( // RL12
    @(posedge hclk) disable iff (!hresetn)
    s_rd_mask |-> ##1 !hreadyout ##1
      hreadyout && (hrdata[17:0] == $past(mask_q)))
    else $error("mask state read wrong");

  AST_RD_RAW: assert property ( // RL13
    @(posedge hclk) disable iff (!hresetn)
    s_rd_raw |-> ##1 !hreadyout ##1
      hreadyout && (hrdata[17:0] == $past(raw_q)))
    else $error("raw status read wrong");

  AST_EVT_STICKY: assert property ( // RL13
    @(posedge hclk) disable iff (!hresetn)
    (rtc_event != '0) |=> ((raw_q & $past(rtc_event)) ==
      $past(rtc_event)))
    else $error("event lost from raw status");

  AST_ZERO_KEEP: assert property ( // RL14
    @(posedge hclk) disable iff (!hresetn)
    (s_set_wr or s_clr_wr) |=>
      ((mask_q & ~$past(hwdata[17:0])) ==
       ($past(mask_q) & ~$past(hwdata[17:0]))))
    else $error("zero bits changed mask state");

  // interrupt line follows raw and mask one cycle late
  AST_IRQ: assert property ( // RL15
    @(posedge hclk) disable iff (!hresetn)
    ((raw_q & mask_q) != '0) |=> rtc_irq)
    else $error("irq missing for unmasked source");

  AST_IRQ_QUIET: assert property ( // RL15
    @(posedge hclk) disable iff (!hresetn)
    ((raw_q & mask_q) == '0) [*2] |-> ##0 !rtc_irq)
    else $error("irq high with nothing pending");

  AST_RESP_OKAY: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0)
    else $error("response not OKAY");

  // writes never stretch their data phase
  AST_WR_NOWAIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (chk_acc && hwrite) |=> hreadyout)
    else $error("write data phase stretched");

  // a read wait lasts exactly one cycle, never longer
  AST_RD_ONEWAIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hreadyout |=> hreadyout)
    else $error("ready low for more than one cycle");

  // read data only moves at the end of a read wait cycle
  AST_RDATA_HOLD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rd_load |=> $stable(hrdata))
    else $error("read data moved outside a read");

  // the write-only places read back as zero
  AST_WO_READ_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn)
    chk_rd_wo |-> ##2 (hrdata == 32'h00000000))
    else $error("write-only place read nonzero");

  // narrow writes and writes elsewhere leave the mask alone
  AST_DEAD_WR_KEEP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_dead_wr |=> $stable(mask_q))
    else $error("mask changed by an ignored write");

  // ones clear raw bits whose event is quiet in that cycle
  AST_RAW_W1C: assert property ( // RL13
    @(posedge hclk) disable iff (!hresetn)
    s_raw_wr ##0 (rtc_event == '0) |=>
      ((raw_q & $past(hwdata[17:0])) == 18'h00000))
    else $error("raw status bits not cleared");

endmodule

/* File: rie_cfg.svh */
// Function
// RL1: set bit 17 unmasks tick interrupt
// RL2: set bit 16 unmasks century rollover
// RL3: set bits 15..9 unmask year..second rollovers
// RL4: set bit 8 unmasks full alarm match
// RL5: set bits 7..0 unmask century..second matches
// RL6: clear bit 17 masks tick interrupt
// RL7: clear bit 16 masks century rollover
// RL8: clear bits 15..9 mask year..second rollovers
// RL9: clear bit 8 masks full alarm match
// RL10: clear bits 7..0 mask century..second matches
// RL11: reserved bits 31..18 read as zero
// RL12: mask state word readable, zero after reset
// RL13: raw status word readable, ignores masking
// RL14: zeros change nothing; clear beats set
// RL15: interrupt when raw and unmask both one
`ifndef RIE_CFG_SVH
`define RIE_CFG_SVH

// register byte offsets within the slave window
`define RIE_ADDR_W 8
`define RIE_OFS_SET 8'h20
`define RIE_OFS_CLR 8'h24
`define RIE_OFS_MASK 8'h28
`define RIE_OFS_RAW 8'h2C

// source field layout, shared by every register
`define RIE_SRC_W 18
`define RIE_RSV_W 14
`define RIE_BIT_TICK 17
`define RIE_BIT_CEN 16
`define RIE_ROLL_HI 15
`define RIE_ROLL_LO 9
`define RIE_BIT_ALL 8
`define RIE_MATCH_HI 7
`define RIE_MATCH_LO 0

// reset values
`define RIE_MASK_RST 18'h00000
`define RIE_RAW_RST 18'h00000
`define RIE_RDATA_RST 32'h00000000

// bus encodings
`define RIE_HSIZE_WORD 3'h2
`define RIE_HRESP_OKAY 1'b0

`endif

/* File: rie_pkg.sv */
`include "rie_cfg.svh"
package rie_pkg;

  // bus front end states, one-hot
  typedef enum logic [1:0] {
    RIE_ST_IDLE = 2'h1,
    RIE_ST_RDWAIT = 2'h2
  } rie_bus_st_type;

  // one bit per interrupt source
  typedef logic [`RIE_SRC_W-1:0] rie_src_type;

endpackage

/* File: rie_flag_reg.sv */
`timescale 1ns/1ps
`include "rie_cfg.svh"
module rie_flag_reg
  import rie_pkg::*;
#(
  parameter int W = `RIE_SRC_W,
  parameter bit SET_WINS = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  // per-bit next value; priority picked at elaboration
  logic [W-1:0] flag_d;
  assign flag_d = SET_WINS ? ((q & ~clr) | set) : ((q | set) & ~clr);

  // flags start cleared
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= flag_d;
    end
  end
endmodule

/* File: rie_ahb_front.sv */
`timescale 1ns/1ps
`include "rie_cfg.svh"
module rie_ahb_front
  import rie_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [`RIE_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic wr_en,
  output logic rd_load,
  output logic [`RIE_ADDR_W-1:0] acc_addr
);
  // address phase taken: selected, bus ready, NONSEQ or SEQ
  wire acc = hsel && hready && htrans[1];
  // only whole-word writes touch registers; others end OKAY
  wire acc_wr = acc && hwrite && (hsize == `RIE_HSIZE_WORD);
  wire acc_rd = acc && !hwrite;

  rie_bus_st_type state_q; // read wait sequencer
  logic wphase_q; // write data phase in progress
  logic ready_q; // registered hreadyout

  // writes commit at the end of their zero-wait data phase
  assign wr_en = wphase_q;
  // read data is sampled at the end of the wait cycle
  assign rd_load = (state_q == RIE_ST_RDWAIT);
  assign hreadyout = ready_q;

  // one wait state on reads lets a preceding write land first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= RIE_ST_IDLE;
      ready_q <= 1'b1;
      wphase_q <= 1'b0;
      acc_addr <= '0;
    end else begin
      wphase_q <= acc_wr;
      if (acc) begin
        acc_addr <= haddr;
      end
      case (state_q)
        RIE_ST_IDLE: begin
          if (acc_rd) begin
            state_q <= RIE_ST_RDWAIT;
            ready_q <= 1'b0;
          end
        end
        RIE_ST_RDWAIT: begin
          state_q <= RIE_ST_IDLE;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= RIE_ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end
endmodule

/* File: rie_rtc_irq_ctrl_tb.sv */
`timescale 1ns/1ps
`include "rie_cfg.svh"
module rie_rtc_irq_ctrl_tb
  import rie_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rtc_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  rie_src_type rtc_event; // raw source levels into the block
  rie_src_type mask_m; // bench copy of the mask state
  logic [31:0] exp_q[$]; // expected read words, oldest first
  logic [31:0] seed; // xorshift state
  logic rd_dp; // a read data phase is in progress
  int num_errors, compares, i;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  rie_rtc_irq_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rtc_event(rtc_event), .rtc_irq(rtc_irq)
  );

  // 125 MHz clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // 32-bit xorshift
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic results();
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp || hresp !== `RIE_HRESP_OKAY) begin
      num_errors++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  // irq is registered, so give the change a few edges to land
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    compares++;
    if (rtc_irq !== exp) begin
      num_errors++;
      $display("wrong value at %0t: irq %b expected %b", $time, rtc_irq, exp);
    end
    @(posedge hclk);
  endtask

  // ready seen at the falling edge is what the next rising edge samples
  task automatic wait_rdy();
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= sz;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, `RIE_HSIZE_WORD);
  endtask

  // byte-sized write: the block must end it OKAY and ignore it
  task automatic wr_narrow(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 3'h0);
  endtask

  // note the expected word first, the monitor compares it later
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, a, 32'h0, `RIE_HSIZE_WORD);
  endtask

  // monitor: takes read data when a read data phase completes
  always @(negedge hclk) begin
    if (rd_dp && hready === 1'b1) begin
      chk_data(hrdata, exp_q.pop_front());
    end
    if (hready === 1'b1) begin
      rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end

  // watchdog: far beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    results();
  end

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    rtc_event = '0;
    hresetn = 1'b0;
    rd_dp = 1'b0;
    seed = 32'h60;
    mask_m = '0;
    num_errors = 0;
    compares = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, write-only places and an unmapped word
    rd(`RIE_OFS_MASK, 32'h0);
    rd(`RIE_OFS_RAW, 32'h0);
    rd(`RIE_OFS_SET, 32'h0);
    rd(`RIE_OFS_CLR, 32'h0);
    rd(8'h30, 32'h0);
    chk_irq(1'b0);
    // unmask one source at a time, the others must hold
    for (i = 0; i < 18; i++) begin
      wr(`RIE_OFS_SET, 32'h1 << i);
      mask_m[i] = 1'b1;
      rd(`RIE_OFS_MASK, {14'h0, mask_m});
    end
    for (i = 0; i < 18; i++) begin
      wr(`RIE_OFS_CLR, 32'h1 << i);
      mask_m[i] = 1'b0;
      rd(`RIE_OFS_MASK, {14'h0, mask_m});
    end
    // random words; software keeps the reserved bits at zero
    repeat (8) begin
      seed = xs(seed);
      wr(`RIE_OFS_SET, {14'h0, seed[17:0]});
      mask_m = mask_m | seed[17:0];
      rd(`RIE_OFS_MASK, {14'h0, mask_m});
      seed = xs(seed);
      wr(`RIE_OFS_CLR, {14'h0, seed[17:0]});
      mask_m = mask_m & ~seed[17:0];
      rd(`RIE_OFS_MASK, {14'h0, mask_m});
    end
    rd(`RIE_OFS_SET, 32'h0);
    // a reset in mid-run must drop every unmask bit
    wr(`RIE_OFS_SET, 32'h0003FFFF);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    mask_m = '0;
    rd(`RIE_OFS_MASK, 32'h0);
    // narrow writes and writes to the mask state word change nothing
    wr_narrow(`RIE_OFS_SET, 32'h0003FFFF);
    wr(`RIE_OFS_MASK, 32'h0003FFFF);
    rd(`RIE_OFS_MASK, 32'h0);
    wr(`RIE_OFS_CLR, 32'h0003FFFF);
    // each source: latch, unmask, mask, unmask again, acknowledge
    for (i = 0; i < 18; i++) begin
      rtc_event <= rie_src_type'(18'h1 << i);
      @(posedge hclk);
      rtc_event <= '0;
      rd(`RIE_OFS_RAW, 32'h1 << i);
      chk_irq(1'b0);
      wr(`RIE_OFS_SET, 32'h1 << i);
      chk_irq(1'b1);
      wr(`RIE_OFS_CLR, 32'h1 << i);
      chk_irq(1'b0);
      wr(`RIE_OFS_SET, 32'h1 << i);
      chk_irq(1'b1);
      wr(`RIE_OFS_RAW, 32'h1 << i);
      chk_irq(1'b0);
      wr(`RIE_OFS_CLR, 32'h1 << i);
    end
    results();
  end
endmodule
